//--- rtl/aemd_pkg.sv
/*
 * aemd_pkg: addressing mode codes, request and result carriers, per-mode
 * byte counts for the addressing mode decoder.
 * assumes a 16-bit byte-addressed cpu bus and 8-bit index registers.
 */
package aemd_pkg;

    typedef enum logic [4:0] {
        AM_INH, AM_IMM, AM_DIR_S, AM_DIR_L, AM_IDX_0, AM_IDX_S, AM_IDX_L,
        AM_IND_S, AM_IND_L, AM_IIX_S, AM_IIX_L, AM_REL_D, AM_REL_I,
        AM_BIT_D, AM_BIT_I, AM_BTR_D, AM_BTR_I
    } aemd_mode_t;

    localparam int unsigned MODE_COUNT = 17;
    localparam logic [15:0] ZERO_PAGE_BASE = 16'h0000;
    localparam logic [15:0] ZERO_PAGE_TOP = 16'h00FF;
    localparam logic [15:0] SHORT_IDX_TOP = 16'h01FE;
    localparam logic [1:0] IDX_SEL_X = 2'h0;
    localparam logic [15:0] ONE = 16'h0001;

    typedef struct packed {
        aemd_mode_t mode;
        logic idx_y;
        logic rmw;
        logic [15:0] opc_addr;
    } aemd_req_t;

    typedef struct packed {
        logic [15:0] ea;
        logic [7:0] operand;
        logic [15:0] target;
        logic [15:0] next_pc;
        logic [1:0] code_len;
        logic illegal;
    } aemd_res_t;

    // bytes that follow the opcode in the code stream
    function automatic logic [1:0] code_len(input aemd_mode_t m);
        logic [1:0] n;
        n = 2'd1;
        unique case (m)
            AM_INH, AM_IDX_0: n = 2'd0;
            AM_DIR_L, AM_IDX_L, AM_BTR_D, AM_BTR_I: n = 2'd2;
            default: n = 2'd1;
        endcase
        return n;
    endfunction

    // bytes of pointer read from the zero page
    function automatic logic [1:0] ptr_len(input aemd_mode_t m);
        logic [1:0] n;
        n = 2'd0;
        unique case (m)
            AM_IND_S, AM_IIX_S, AM_REL_I, AM_BIT_I, AM_BTR_I: n = 2'd1;
            AM_IND_L, AM_IIX_L: n = 2'd2;
            default: n = 2'd0;
        endcase
        return n;
    endfunction

    function automatic logic is_long(input aemd_mode_t m);
        return (m == AM_DIR_L) || (m == AM_IDX_L) || (m == AM_IND_L) ||
            (m == AM_IIX_L);
    endfunction

endpackage

//--- rtl/aemd_decoder.sv
/*
 * aemd_decoder: fetches the operand bytes of one instruction, reads any
 * zero-page pointer and forms the effective address.
 * assumes a single-master read port: the request holds until mem_ack,
 * which comes with mem_rdata in the same cycle.
 */
// Notes on behaviour
// - seventeen addressing modes are decoded in nine groups.
// - short direct and indirect forms address only the zero page 0000h to 00FFh; short forms take fewer bytes.
// - read-modify-write instructions are refused in any long form.
// - an inherent instruction is the opcode alone and fetches nothing more.
// - an immediate instruction has one byte after the opcode used as the operand.
// - short direct fetches one byte used as an address 00 to FF.
// - long direct fetches a two-byte address anywhere in 64 Kbyte.
// - indexed addresses are the unsigned sum of X or Y and the offset.
// - no-offset indexed fetches nothing and the index alone is the address.
// - short indexed adds a one-byte offset to the index, reaching 00 to 1FE.
// - long indexed adds a two-byte offset to the index over 64 Kbyte.
// - indirect modes read a pointer at the zero-page address after the opcode.
// - short indirect reads a one-byte pointer giving 00 to FF.
// - long indirect reads a two-byte pointer giving any 64 Kbyte address.
`timescale 1ns/1ps
`default_nettype none

module aemd_decoder (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic start,
    input wire aemd_pkg::aemd_req_t req,
    input wire logic [7:0] x_reg,
    input wire logic [7:0] y_reg,
    output logic busy,
    output logic mem_rd,
    output logic [15:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    output logic done,
    output aemd_pkg::aemd_res_t res
);

    typedef enum logic [1:0] {ST_IDLE, ST_CODE, ST_PTR, ST_CALC} aemd_state_t;

    aemd_state_t state_r, state_nxt;
    aemd_pkg::aemd_mode_t mode_r, mode_nxt;
    logic [15:0] opc_r, opc_nxt;
    logic [7:0] idx_r, idx_nxt;
    logic [7:0] b1_r, b1_nxt, b2_r, b2_nxt;
    logic [7:0] p1_r, p1_nxt, p2_r, p2_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic busy_r, busy_nxt;
    logic rd_r, rd_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic done_r, done_nxt;
    aemd_pkg::aemd_res_t res_r, res_nxt;

    logic [1:0] clen, plen;
    logic [15:0] npc, zidx, ptr_base;

    assign clen = aemd_pkg::code_len(mode_r);
    assign plen = aemd_pkg::ptr_len(mode_r);
    assign npc = opc_r + aemd_pkg::ONE + {14'h0000, clen};
    assign zidx = {8'h00, idx_r};
    assign ptr_base = {8'h00, b1_r};

    always_comb begin
        state_nxt = state_r;
        mode_nxt = mode_r;
        opc_nxt = opc_r;
        idx_nxt = idx_r;
        b1_nxt = b1_r;
        b2_nxt = b2_r;
        p1_nxt = p1_r;
        p2_nxt = p2_r;
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        rd_nxt = rd_r;
        addr_nxt = addr_r;
        done_nxt = 1'b0;
        res_nxt = res_r;
        unique case (state_r)
            ST_IDLE: begin
                if (start) begin
                    mode_nxt = req.mode;
                    opc_nxt = req.opc_addr;
                    idx_nxt = req.idx_y ? y_reg : x_reg;
                    cnt_nxt = 2'd0;
                    b1_nxt = 8'h00;
                    b2_nxt = 8'h00;
                    p1_nxt = 8'h00;
                    p2_nxt = 8'h00;
                    if (req.rmw && aemd_pkg::is_long(req.mode)) begin
                        // refused before any bus cycle is spent
                        res_nxt = '0;
                        res_nxt.illegal = 1'b1;
                        res_nxt.next_pc = req.opc_addr + aemd_pkg::ONE;
                        done_nxt = 1'b1;
                    end else if (aemd_pkg::code_len(req.mode) == 2'd0) begin
                        // inherent and no-offset indexed touch no code byte
                        busy_nxt = 1'b1;
                        state_nxt = ST_CALC;
                    end else begin
                        busy_nxt = 1'b1;
                        rd_nxt = 1'b1;
                        addr_nxt = req.opc_addr + aemd_pkg::ONE;
                        state_nxt = ST_CODE;
                    end
                end
            end
            ST_CODE: begin
                if (mem_ack) begin
                    if (cnt_r == 2'd0) begin
                        b1_nxt = mem_rdata;
                    end else begin
                        b2_nxt = mem_rdata;
                    end
                    if (cnt_r + 2'd1 < clen) begin
                        cnt_nxt = cnt_r + 2'd1;
                        addr_nxt = addr_r + aemd_pkg::ONE;
                    end else if (plen != 2'd0) begin
                        // pointer always sits in the zero page
                        cnt_nxt = 2'd0;
                        addr_nxt = {8'h00, (cnt_r == 2'd0) ? mem_rdata : b1_r};
                        state_nxt = ST_PTR;
                    end else begin
                        rd_nxt = 1'b0;
                        state_nxt = ST_CALC;
                    end
                end
            end
            ST_PTR: begin
                if (mem_ack) begin
                    if (cnt_r == 2'd0) begin
                        p1_nxt = mem_rdata;
                    end else begin
                        p2_nxt = mem_rdata;
                    end
                    if (cnt_r + 2'd1 < plen) begin
                        cnt_nxt = cnt_r + 2'd1;
                        // wraps at 00FF, so a long pointer at 00FF takes its second byte from 0000
                        addr_nxt = ptr_base + aemd_pkg::ONE;
                        addr_nxt[15:8] = 8'h00;
                    end else begin
                        rd_nxt = 1'b0;
                        state_nxt = ST_CALC;
                    end
                end
            end
            ST_CALC: begin
                res_nxt = '0;
                res_nxt.next_pc = npc;
                res_nxt.code_len = clen;
                unique case (mode_r)
                    aemd_pkg::AM_INH: res_nxt.ea = 16'h0000;
                    aemd_pkg::AM_IMM: begin
                        res_nxt.ea = opc_r + aemd_pkg::ONE;
                        res_nxt.operand = b1_r;
                    end
                    aemd_pkg::AM_DIR_S: res_nxt.ea = {8'h00, b1_r};
                    aemd_pkg::AM_DIR_L: res_nxt.ea = {b1_r, b2_r};
                    aemd_pkg::AM_IDX_0: res_nxt.ea = zidx;
                    aemd_pkg::AM_IDX_S: res_nxt.ea = {8'h00, b1_r} + zidx;
                    aemd_pkg::AM_IDX_L: res_nxt.ea = {b1_r, b2_r} + zidx;
                    aemd_pkg::AM_IND_S: res_nxt.ea = {8'h00, p1_r};
                    aemd_pkg::AM_IND_L: res_nxt.ea = {p1_r, p2_r};
                    aemd_pkg::AM_IIX_S: res_nxt.ea = {8'h00, p1_r} + zidx;
                    aemd_pkg::AM_IIX_L: res_nxt.ea = {p1_r, p2_r} + zidx;
                    aemd_pkg::AM_REL_D: begin
                        res_nxt.target = npc + {{8{b1_r[7]}}, b1_r};
                        res_nxt.ea = res_nxt.target;
                    end
                    aemd_pkg::AM_REL_I: begin
                        res_nxt.target = npc + {{8{p1_r[7]}}, p1_r};
                        res_nxt.ea = res_nxt.target;
                    end
                    aemd_pkg::AM_BIT_D: res_nxt.ea = {8'h00, b1_r};
                    aemd_pkg::AM_BIT_I: res_nxt.ea = {8'h00, p1_r};
                    aemd_pkg::AM_BTR_D: begin
                        res_nxt.ea = {8'h00, b1_r};
                        res_nxt.target = npc + {{8{b2_r[7]}}, b2_r};
                    end
                    aemd_pkg::AM_BTR_I: begin
                        res_nxt.ea = {8'h00, p1_r};
                        res_nxt.target = npc + {{8{b2_r[7]}}, b2_r};
                    end
                endcase
                done_nxt = 1'b1;
                busy_nxt = 1'b0;
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            mode_r <= aemd_pkg::AM_INH;
            opc_r <= 16'h0000;
            idx_r <= 8'h00;
            b1_r <= 8'h00;
            b2_r <= 8'h00;
            p1_r <= 8'h00;
            p2_r <= 8'h00;
            cnt_r <= 2'd0;
            busy_r <= 1'b0;
            rd_r <= 1'b0;
            addr_r <= 16'h0000;
            done_r <= 1'b0;
            res_r <= '0;
        end else begin
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            opc_r <= opc_nxt;
            idx_r <= idx_nxt;
            b1_r <= b1_nxt;
            b2_r <= b2_nxt;
            p1_r <= p1_nxt;
            p2_r <= p2_nxt;
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            rd_r <= rd_nxt;
            addr_r <= addr_nxt;
            done_r <= done_nxt;
            res_r <= res_nxt;
        end
    end

    assign busy = busy_r;
    assign mem_rd = rd_r;
    assign mem_addr = addr_r;
    assign done = done_r;
    assign res = res_r;

endmodule

`default_nettype wire

//--- rtl/aemd_tail_placeholder_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- tb/aemd_decoder_monitor.sv
/* aemd_decoder_monitor: port-level checks of the addressing mode decoder.
   assumes one clock domain and a partner that acks only pending reads. */
`timescale 1ns/1ps
`default_nettype none
module aemd_decoder_monitor (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic start,
    input wire aemd_pkg::aemd_req_t req,
    input wire logic [7:0] x_reg,
    input wire logic [7:0] y_reg,
    input wire logic busy,
    input wire logic mem_rd,
    input wire logic [15:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    input wire logic done,
    input wire aemd_pkg::aemd_res_t res
);
    logic take, lng, nof;
    aemd_pkg::aemd_mode_t mode_r, mode_nxt;
    logic [15:0] opc_r, opc_nxt;
    assign take = start && !busy;
    assign lng = req.mode inside {aemd_pkg::AM_DIR_L, aemd_pkg::AM_IDX_L,
        aemd_pkg::AM_IND_L, aemd_pkg::AM_IIX_L};
    assign nof = req.mode inside {aemd_pkg::AM_INH, aemd_pkg::AM_IDX_0};
    always_comb begin
        mode_nxt = take ? req.mode : mode_r;
        opc_nxt = take ? req.opc_addr : opc_r;
    end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mode_r <= aemd_pkg::AM_INH;
            opc_r <= 16'h0000;
        end else begin
            mode_r <= mode_nxt;
            opc_r <= opc_nxt;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_illegal_fast: assert property (take && req.rmw && lng |=>
        done && res.illegal && !busy && !mem_rd)
        else $error("long form with rmw not refused at once");
    a_first_fetch: assert property (take && !(req.rmw && lng) && !nof |=>
        mem_rd && mem_addr == opc_r + 16'h0001)
        else $error("first operand read not at opcode plus one");
    a_no_fetch: assert property (take && nof |=> !mem_rd ##1 (done && !mem_rd))
        else $error("fetch seen for a mode with no operand bytes");
    a_addr_hold: assert property (mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr))
        else $error("read dropped or moved before ack");
    a_done_bound: assert property (take |-> ##[1:40] done)
        else $error("no result within 40 cycles");
    a_next_pc: assert property (done |->
        res.next_pc == opc_r + 16'h0001 + {14'h0000, res.code_len})
        else $error("next pc does not follow code length");
    a_zero_page: assert property (done && mode_r inside {aemd_pkg::AM_DIR_S, aemd_pkg::AM_IDX_0,
        aemd_pkg::AM_IND_S, aemd_pkg::AM_BIT_D} |-> res.ea[15:8] == 8'h00)
        else $error("short form left the zero page");
    a_long_len: assert property (done && !res.illegal && mode_r inside {aemd_pkg::AM_DIR_L,
        aemd_pkg::AM_IDX_L} |-> res.code_len == 2'h2)
        else $error("long form without two code bytes");
    c_illegal: cover property (done && res.illegal);
    c_wait: cover property (mem_rd && !mem_ack);
    c_iix_long: cover property (done && mode_r == aemd_pkg::AM_IIX_L);
endmodule
bind aemd_decoder aemd_decoder_monitor i_aemd_decoder_monitor (.clock(clock), .reset_n(reset_n),
    .start(start), .req(req), .x_reg(x_reg), .y_reg(y_reg), .busy(busy), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .done(done), .res(res));
`default_nettype wire

//--- tb/aemd_mem_model.sv
/* aemd_mem_model: byte memory on the cpu bus, prompt or two waits.
   assumes one outstanding read; contents loaded by the bench. */
`timescale 1ns/1ps
`default_nettype none
module aemd_mem_model (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic slow,
    input wire logic mem_rd,
    input wire logic [15:0] mem_addr,
    output logic mem_ack,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:65535];
    logic [1:0] wait_r;
    logic [7:0] last_r;
    // ack only while a read is pending
    assign mem_ack = mem_rd && (wait_r >= (slow ? 2'h2 : 2'h0));
    // without ack the bus shows the inverse of last cycle's value, so it alternates and stale data returns every other cycle
    assign mem_rdata = mem_ack ? mem[mem_addr] : ~last_r;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wait_r <= 2'h0;
            last_r <= 8'h00;
        end else begin
            wait_r <= (mem_rd && !mem_ack) ? wait_r + 2'h1 : 2'h0;
            last_r <= mem_rdata;
        end
    end
endmodule
`default_nettype wire

//--- tb/aemd_decoder_tb_top.sv
/* aemd_decoder_tb_top: every mode, random index and opcode address.
   assumes the memory model holds random bytes loaded at time zero. */
`timescale 1ns/1ps
`default_nettype none
module aemd_decoder_tb_top;
    logic clock, reset_n, start, busy, mem_rd, mem_ack, done, slow;
    logic [7:0] x_reg, y_reg, mem_rdata;
    logic [15:0] mem_addr;
    aemd_pkg::aemd_req_t req;
    aemd_pkg::aemd_res_t res, want, exp_q[$];
    int mismatches, checks_done, cycles;
    logic [31:0] seed;
    aemd_decoder i_aemd_decoder (.clock(clock), .reset_n(reset_n), .start(start), .req(req),
        .x_reg(x_reg), .y_reg(y_reg), .busy(busy), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .done(done), .res(res));
    aemd_mem_model i_aemd_mem_model (.clock(clock), .reset_n(reset_n), .slow(slow),
        .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic aemd_pkg::aemd_res_t exp_of(aemd_pkg::aemd_mode_t m, logic rmw,
            logic [7:0] ix, logic [15:0] o);
        aemd_pkg::aemd_res_t r;
        logic [7:0] b1, b2, p1, p2, off;
        r = '0;
        b1 = i_aemd_mem_model.mem[o + 16'h0001];
        b2 = i_aemd_mem_model.mem[o + 16'h0002];
        p1 = i_aemd_mem_model.mem[{8'h00, b1}];
        p2 = i_aemd_mem_model.mem[{8'h00, b1 + 8'h01}];
        r.next_pc = o + 16'h0001;
        if (rmw && m inside {aemd_pkg::AM_DIR_L, aemd_pkg::AM_IDX_L, aemd_pkg::AM_IND_L,
                aemd_pkg::AM_IIX_L}) begin
            r.illegal = 1'b1;
            return r;
        end
        r.code_len = m inside {aemd_pkg::AM_INH, aemd_pkg::AM_IDX_0} ? 2'h0 :
            m inside {aemd_pkg::AM_DIR_L, aemd_pkg::AM_IDX_L, aemd_pkg::AM_BTR_D,
            aemd_pkg::AM_BTR_I} ? 2'h2 : 2'h1;
        r.next_pc = r.next_pc + {14'h0000, r.code_len};
        case (m)
            aemd_pkg::AM_IMM: r.ea = o + 16'h0001;
            aemd_pkg::AM_DIR_S, aemd_pkg::AM_BIT_D,
            aemd_pkg::AM_BTR_D: r.ea = {8'h00, b1};
            aemd_pkg::AM_DIR_L: r.ea = {b1, b2};
            aemd_pkg::AM_IDX_0: r.ea = {8'h00, ix};
            aemd_pkg::AM_IDX_S: r.ea = {8'h00, b1} + {8'h00, ix};
            aemd_pkg::AM_IDX_L: r.ea = {b1, b2} + {8'h00, ix};
            aemd_pkg::AM_IND_S, aemd_pkg::AM_BIT_I,
            aemd_pkg::AM_BTR_I: r.ea = {8'h00, p1};
            aemd_pkg::AM_IND_L: r.ea = {p1, p2};
            aemd_pkg::AM_IIX_S: r.ea = {8'h00, p1} + {8'h00, ix};
            aemd_pkg::AM_IIX_L: r.ea = {p1, p2} + {8'h00, ix};
            default: r.ea = 16'h0000;
        endcase
        r.operand = (m == aemd_pkg::AM_IMM) ? b1 : 8'h00;
        off = (m == aemd_pkg::AM_REL_D) ? b1 : (m == aemd_pkg::AM_REL_I) ? p1 : b2;
        if (m inside {aemd_pkg::AM_REL_D, aemd_pkg::AM_REL_I, aemd_pkg::AM_BTR_D,
                aemd_pkg::AM_BTR_I}) begin
            r.target = r.next_pc + {{8{off[7]}}, off};
        end
        if (m inside {aemd_pkg::AM_REL_D, aemd_pkg::AM_REL_I}) begin
            r.ea = r.target;
        end
        return r;
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic run_op(aemd_pkg::aemd_mode_t m, logic rmw);
        logic [31:0] r;
        r = rnd();
        @(posedge clock);
        start <= 1'b1;
        req <= '{mode: m, idx_y: r[0], rmw: rmw, opc_addr: r[31:16]};
        x_reg <= r[15:8];
        y_reg <= r[7:0];
        slow <= r[1];
        exp_q.push_back(exp_of(m, rmw, r[0] ? r[7:0] : r[15:8], r[31:16]));
        @(posedge clock);
        // second start while busy must be ignored; index moves too late to count
        start <= !exp_q[$].illegal;
        req.opc_addr <= r[15:0];
        x_reg <= ~r[15:8];
        @(posedge clock);
        start <= 1'b0;
        @(negedge clock);
        while (busy === 1'b1) @(negedge clock);
    endtask
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (reset_n === 1'b1 && done === 1'b1) begin
            want = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
            checks_done++;
            if (res !== want) begin
                mismatches++;
                $display("unexpected at %0t: result %h want %h", $time, res, want);
            end
        end
        // a hang still ends in the one verdict
        if (cycles > 20000) begin
            mismatches++;
            $display("unexpected at %0t: run did not finish in time", $time);
            final_report();
        end
    end
    initial begin
        seed = 32'h0001_0f8c;
        reset_n = 1'b0;
        start = 1'b0;
        req = '0;
        x_reg = 8'h00;
        y_reg = 8'h00;
        slow = 1'b0;
        mismatches = 0;
        checks_done = 0;
        cycles = 0;
        for (int a = 0; a < 65536; a++) i_aemd_mem_model.mem[a] = 8'(rnd());
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        for (int i = 0; i < 204; i++) begin
            run_op(aemd_pkg::aemd_mode_t'(i % 17), (i / 17) % 2 == 1);
        end
        repeat (4) @(posedge clock);
        if (exp_q.size() != 0) begin
            mismatches++;
            $display("unexpected at %0t: %0d results never appeared", $time, exp_q.size());
        end
        final_report();
    end
endmodule
`default_nettype wire
